// ### bench/iepb_core_model.sv
// Core-side model: takes the offered request on command, reports running level.
// Assumes core_req_i is registered on clk_i and the bench steers take and done.
`timescale 1ns/1ps
`default_nettype none
module iepb_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire iepb_pkg::iepb_core_req_s core_req_i,
  input wire logic take_i,
  input wire logic done_i,
  output logic svc_high_o,
  output logic svc_low_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i || done_i) begin
      svc_high_o <= 1'b0;
      svc_low_o <= 1'b0;
    end else if (take_i && core_req_i.req) begin
      svc_high_o <= svc_high_o | core_req_i.high;
      svc_low_o <= svc_low_o | !core_req_i.high;
    end
  end
endmodule
`default_nettype wire

// ### bench/iepb_core_test.sv
// Self-checking bench for the interrupt enable and priority bank.
// Assumes a classic Wishbone master here and the core model as partner.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); \
  end \
end
module iepb_core_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  iepb_pkg::iepb_flags_s fl = '0;
  logic pin0 = 1'b0;
  logic pin1 = 1'b0;
  logic take = 1'b0;
  logic done = 1'b0;
  logic svc_h;
  logic svc_l;
  iepb_pkg::iepb_core_req_s core_req_o;
  logic irq_o;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] en[18] = '{32'h82, 32'h88, 32'h90, 32'ha0, 32'ha0, 32'hc0, 32'h80, 32'h80,
    32'h40, 32'h40, 32'h20, 32'h20, 32'h10, 32'h08, 32'h04, 32'h02, 32'h01, 32'h01};
  int fb[18] = '{17, 16, 15, 14, 13, 12, 2, 1, 4, 3, 6, 5, 7, 8, 9, 10, 11, 0};
  logic [3:0] sr[18] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'he, 4'he, 4'hd, 4'hd, 4'hc,
    4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'hf};
  always #4 clk = ~clk;
  iepb_core uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flags_i(fl), .ext_input_zero_i(pin0), .ext_input_one_i(pin1),
    .svc_high_i(svc_h), .svc_low_i(svc_l), .core_req_o(core_req_o), .irq_o(irq_o));
  iepb_core_model core (.clk_i(clk), .rst_i(rst), .core_req_i(core_req_o), .take_i(take),
    .done_i(done), .svc_high_o(svc_h), .svc_low_o(svc_l));
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic wr_en, input logic [9:0] ix, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    we <= wr_en;
    adr <= {ix, 2'b00};
    dat <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] ix, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, ix, d, q);
  endtask
  task automatic rd(input logic [9:0] ix, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, ix, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic rw(input logic [9:0] ix, input logic [31:0] d, input logic [31:0] e);
    wr(ix, d);
    rd(ix, e);
  endtask
  task automatic rq(input logic v, input logic h, input logic [3:0] s);
    if (v) `CHK(core_req_o, {1'b1, h, s})
    else `CHK(core_req_o.req, 1'b0)
  endtask
  task automatic t_reset();
    rd(iepb_pkg::IDX_PRI_EN, 32'h0);
    rd(iepb_pkg::IDX_PRI_LVL, 32'h80);
    rd(iepb_pkg::IDX_EXT_EN1, 32'h0);
    rd(iepb_pkg::IDX_EXT_EN2, 32'h0);
    rd(iepb_pkg::IDX_EXT_LVL1, 32'h0);
    rd(iepb_pkg::IDX_EXT_LVL2, 32'h0);
    rq(1'b0, 1'b0, 4'h0);
    $display("t_reset done");
  endtask
  task automatic t_regs();
    rw(iepb_pkg::IDX_PRI_EN, 32'hff, 32'hff);
    rw(iepb_pkg::IDX_PRI_LVL, 32'hff, 32'hff);
    rw(iepb_pkg::IDX_PRI_LVL, 32'h00, 32'h80);
    rw(iepb_pkg::IDX_EXT_EN1, 32'hff, 32'hff);
    rw(iepb_pkg::IDX_EXT_EN2, 32'hff, 32'h01);
    rw(iepb_pkg::IDX_EXT_LVL1, 32'hff, 32'hff);
    rw(iepb_pkg::IDX_EXT_LVL2, 32'hff, 32'h01);
    rw(10'h000, 32'hff, 32'h00);
    rst <= 1'b1;
    w(2);
    rst <= 1'b0;
    $display("t_regs done");
    t_reset();
  endtask
  task automatic t_gate();
    logic [9:0] ix;
    for (int i = 0; i < 18; i++) begin
      ix = i < 6 ? iepb_pkg::IDX_PRI_EN : i < 17 ? iepb_pkg::IDX_EXT_EN1 : iepb_pkg::IDX_EXT_EN2;
      wr(iepb_pkg::IDX_PRI_EN, 32'h80);
      wr(ix, en[i]);
      fl <= 18'h1 << fb[i];
      w(5);
      rq(1'b1, 1'b0, sr[i]);
      wr(iepb_pkg::IDX_PRI_EN, i < 6 ? en[i] & 32'h7f : 32'h0);
      w(3);
      rq(1'b0, 1'b0, 4'h0);
      wr(iepb_pkg::IDX_PRI_EN, 32'h80);
      wr(ix, i < 6 ? 32'h80 : 32'h0);
      w(3);
      rq(1'b0, 1'b0, 4'h0);
      fl <= '0;
    end
    $display("t_gate done");
  endtask
  task automatic t_prio();
    wr(iepb_pkg::IDX_PRI_EN, 32'h92);
    wr(iepb_pkg::IDX_EXT_EN2, 32'h1);
    fl <= 18'h28001;
    w(1);
    rq(1'b0, 1'b0, 4'h0);
    w(1);
    rq(1'b1, 1'b0, 4'h1);
    wr(iepb_pkg::IDX_PRI_LVL, 32'h10);
    w(3);
    rq(1'b1, 1'b1, 4'h4);
    wr(iepb_pkg::IDX_PRI_LVL, 32'h0);
    wr(iepb_pkg::IDX_EXT_LVL2, 32'h1);
    w(3);
    rq(1'b1, 1'b1, 4'hf);
    wr(iepb_pkg::IDX_EXT_LVL2, 32'h0);
    fl <= '0;
    wr(iepb_pkg::IDX_PRI_EN, 32'h85);
    pin1 <= 1'b1;
    w(5);
    rq(1'b1, 1'b0, 4'h2);
    pin0 <= 1'b1;
    w(5);
    rq(1'b1, 1'b0, 4'h0);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    $display("t_prio done");
  endtask
  task automatic t_svc();
    wr(iepb_pkg::IDX_PRI_EN, 32'h92);
    fl <= 18'h28000;
    w(3);
    take <= 1'b1;
    w(1);
    take <= 1'b0;
    w(3);
    rq(1'b0, 1'b0, 4'h0);
    wr(iepb_pkg::IDX_PRI_LVL, 32'h10);
    w(3);
    rq(1'b1, 1'b1, 4'h4);
    take <= 1'b1;
    w(1);
    take <= 1'b0;
    w(3);
    rq(1'b0, 1'b0, 4'h0);
    done <= 1'b1;
    w(1);
    done <= 1'b0;
    w(3);
    rq(1'b1, 1'b1, 4'h4);
    wr(iepb_pkg::IDX_PRI_LVL, 32'h0);
    fl <= '0;
    $display("t_svc done");
  endtask
  task automatic t_irq();
    // Earlier tests raised every source at least once; the read also clears them
    rd(iepb_pkg::IDX_EVT_STAT, 32'hffff);
    wr(iepb_pkg::IDX_EVT_MASK, 32'h2);
    wr(iepb_pkg::IDX_PRI_EN, 32'h82);
    fl <= 18'h20000;
    w(5);
    `CHK(irq_o, 1'b1)
    rd(iepb_pkg::IDX_EVT_STAT, 32'h2);
    w(3);
    `CHK(irq_o, 1'b0)
    rd(iepb_pkg::IDX_EVT_STAT, 32'h0);
    fl <= '0;
    wr(iepb_pkg::IDX_EVT_MASK, 32'h0);
    fl <= 18'h20000;
    w(5);
    `CHK(irq_o, 1'b0)
    rd(iepb_pkg::IDX_EVT_STAT, 32'h2);
    fl <= '0;
    $display("t_irq done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    w(20);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_gate();
    t_prio();
    t_svc();
    t_irq();
    print_verdict();
  end
endmodule
`default_nettype wire

// ### logic/iepb_core.sv
// Interrupt enable and priority bank with arbitration toward the core.
// Assumes flags come from logic on clk_i; the two external inputs are
// asynchronous pins. Core reports which service level is running.
// Functional notes
// R01 - Global enable bit 7 of primary enable overrides all masks.
// R02 - With global enable set, a source passes only if its mask is 1.
// R03 - Primary enable bits 6..0: SPI, timer2, UART, timer1, ext1, timer0, ext0.
// R04 - Timer 2 mask gates both timer 2 low and high overflow flags.
// R05 - Timer 3 mask, extended enable one bit 7, gates both its flags.
// R06 - Comparator masks bits 6,5 gate rise or fall flags.
// R07 - Extended enable one bits 4..0: PCA, ADC done, window, USB, SMBus.
// R08 - Level bit 0 means low, 1 high; primary level mirrors enable.
// R09 - Primary level bit 7 reads 1, writes ignored.
// R10 - Extended level one mirrors extended enable one layout.
// R11 - Extended enable two bit 0 masks the supply sense request.
// R12 - Extended enable two bits 7..1 read zero, writes ignored.
// R13 - High preempts low service; nothing preempts high service.
// R14 - High level served first; equal level by fixed order from 0.
// R15 - Requests sampled and decoded each clock, one cycle to detect a flag, three for an external input pin.
// R16 - Supply sense level set by bit 0 of extended level two.
// R17 - Core gets request, level and winning source, every clock.
// R18 - Reset clears all enables and levels, all masked and low.
`timescale 1ns/1ps
`default_nettype none
module iepb_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [iepb_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire iepb_pkg::iepb_flags_s flags_i,
  input wire logic ext_input_zero_i,
  input wire logic ext_input_one_i,
  input wire logic svc_high_i,
  input wire logic svc_low_i,
  output iepb_pkg::iepb_core_req_s core_req_o,
  output logic irq_o
);
  function automatic logic hit(input logic [9:0] idx, input logic [9:0] a);
    hit = (idx == a);
  endfunction

  // Lowest set index wins; bit 4 flags any set
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = iepb_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    first_set = r;
  endfunction

  logic [7:0] pri_en_q, pri_en_d;
  logic [7:0] pri_lvl_q, pri_lvl_d;
  logic [7:0] ext_en1_q, ext_en1_d;
  logic [7:0] ext_en2_q, ext_en2_d;
  logic [7:0] ext_lvl1_q, ext_lvl1_d;
  logic [7:0] ext_lvl2_q, ext_lvl2_d;
  logic [15:0] evt_q, evt_d;
  logic [15:0] evt_mask_q, evt_mask_d;
  logic [15:0] raw_q;
  logic [1:0] x0_sync_q, x1_sync_q;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic irq_q, irq_d;
  iepb_pkg::iepb_core_req_s req_q, req_d;

  logic [15:0] raw, mask_vec, lvl_vec, gated, hi_vec, lo_vec;
  logic [4:0] hi_pick, lo_pick;
  logic [9:0] idx;
  logic access, rd_stat;

  assign idx = wb_adr_i[iepb_pkg::ADR_W-1:2];
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign rd_stat = access && !wb_we_i && hit(idx, iepb_pkg::IDX_EVT_STAT);

  // Per-source request in fixed order 0..15
  always_comb begin
    raw = {flags_i.supply_sense_flag,
           flags_i.timer_three_low_overflow_flag |
             flags_i.timer_three_high_overflow_flag, // R05
           flags_i.comparator_one_rise_flag |
             flags_i.comparator_one_fall_flag, // R06
           flags_i.comparator_zero_rise_flag |
             flags_i.comparator_zero_fall_flag, // R06
           flags_i.counter_array_flag,
           flags_i.conversion_done_flag,
           flags_i.window_compare_flag,
           flags_i.usb_function_flag,
           flags_i.smbus_flag,
           flags_i.serial_periph_flag,
           flags_i.timer_two_low_overflow_flag |
             flags_i.timer_two_high_overflow_flag, // R04
           flags_i.uart_flag,
           flags_i.timer_one_overflow_flag,
           x1_sync_q[1],
           flags_i.timer_zero_overflow_flag,
           x0_sync_q[1]};
  end

  // Mask and level vectors in source order
  assign mask_vec = {ext_en2_q[iepb_pkg::SUPPLY_BIT], ext_en1_q, pri_en_q[6:0]}; // R03 R07 R11
  assign lvl_vec = {ext_lvl2_q[iepb_pkg::SUPPLY_BIT], ext_lvl1_q, pri_lvl_q[6:0]}; // R08 R10 R16

  always_comb begin
    gated = raw & mask_vec & {iepb_pkg::NSRC{pri_en_q[iepb_pkg::GIE_BIT]}}; // R01 R02
    hi_vec = gated & lvl_vec; // R08
    lo_vec = gated & ~lvl_vec;
    hi_pick = first_set(hi_vec); // R14
    lo_pick = first_set(lo_vec); // R14
    req_d.req = 1'b0;
    req_d.high = 1'b0;
    req_d.src = hi_pick[3:0];
    if (!svc_high_i && hi_pick[4]) begin // R13
      req_d.req = 1'b1;
      req_d.high = 1'b1;
    end else if (!svc_high_i && !svc_low_i && lo_pick[4]) begin // R13
      req_d.req = 1'b1;
      req_d.src = lo_pick[3:0];
    end
  end

  // Register file and bus answer
  always_comb begin
    pri_en_d = pri_en_q;
    pri_lvl_d = pri_lvl_q;
    ext_en1_d = ext_en1_q;
    ext_en2_d = ext_en2_q;
    ext_lvl1_d = ext_lvl1_q;
    ext_lvl2_d = ext_lvl2_q;
    evt_mask_d = evt_mask_q;
    ack_d = access;
    dat_d = 32'h0000_0000;
    if (access && wb_we_i && wb_sel_i[0]) begin
      if (hit(idx, iepb_pkg::IDX_PRI_EN)) begin
        pri_en_d = wb_dat_i[7:0];
      end
      if (hit(idx, iepb_pkg::IDX_PRI_LVL)) begin
        pri_lvl_d = wb_dat_i[7:0] & iepb_pkg::LOW7_MASK; // R09
      end
      if (hit(idx, iepb_pkg::IDX_EXT_EN1)) begin
        ext_en1_d = wb_dat_i[7:0];
      end
      if (hit(idx, iepb_pkg::IDX_EXT_EN2)) begin
        ext_en2_d = wb_dat_i[7:0] & iepb_pkg::BIT0_MASK; // R12
      end
      if (hit(idx, iepb_pkg::IDX_EXT_LVL1)) begin
        ext_lvl1_d = wb_dat_i[7:0];
      end
      if (hit(idx, iepb_pkg::IDX_EXT_LVL2)) begin
        ext_lvl2_d = wb_dat_i[7:0] & iepb_pkg::BIT0_MASK;
      end
      if (hit(idx, iepb_pkg::IDX_EVT_MASK)) begin
        evt_mask_d[7:0] = wb_dat_i[7:0];
      end
    end
    if (access && wb_we_i && wb_sel_i[1] && hit(idx, iepb_pkg::IDX_EVT_MASK)) begin
      evt_mask_d[15:8] = wb_dat_i[15:8];
    end
    if (access && !wb_we_i) begin
      case (idx)
        iepb_pkg::IDX_PRI_EN: dat_d[7:0] = pri_en_q;
        iepb_pkg::IDX_PRI_LVL: dat_d[7:0] = pri_lvl_q | iepb_pkg::PRI_LVL_FIXED; // R09
        iepb_pkg::IDX_EXT_EN1: dat_d[7:0] = ext_en1_q;
        iepb_pkg::IDX_EXT_EN2: dat_d[7:0] = ext_en2_q & iepb_pkg::BIT0_MASK; // R12
        iepb_pkg::IDX_EXT_LVL1: dat_d[7:0] = ext_lvl1_q;
        iepb_pkg::IDX_EXT_LVL2: dat_d[7:0] = ext_lvl2_q & iepb_pkg::BIT0_MASK;
        iepb_pkg::IDX_EVT_STAT: dat_d[15:0] = evt_q;
        iepb_pkg::IDX_EVT_MASK: dat_d[15:0] = evt_mask_q;
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  // Sticky event on a new enabled request; a set beats a read clear
  always_comb begin
    evt_d = evt_q;
    if (rd_stat) begin
      evt_d = iepb_pkg::RST_EVT;
    end
    evt_d = evt_d | (gated & ~raw_q);
    irq_d = |(evt_q & evt_mask_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_en_q <= iepb_pkg::RST_REG; // R18
      pri_lvl_q <= iepb_pkg::RST_REG; // R18
      ext_en1_q <= iepb_pkg::RST_REG;
      ext_en2_q <= iepb_pkg::RST_REG;
      ext_lvl1_q <= iepb_pkg::RST_REG;
      ext_lvl2_q <= iepb_pkg::RST_REG;
      evt_q <= iepb_pkg::RST_EVT;
      evt_mask_q <= iepb_pkg::RST_EVT;
      raw_q <= iepb_pkg::RST_EVT;
      x0_sync_q <= 2'h0;
      x1_sync_q <= 2'h0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      req_q <= '0;
    end else begin
      pri_en_q <= pri_en_d;
      pri_lvl_q <= pri_lvl_d;
      ext_en1_q <= ext_en1_d;
      ext_en2_q <= ext_en2_d;
      ext_lvl1_q <= ext_lvl1_d;
      ext_lvl2_q <= ext_lvl2_d;
      evt_q <= evt_d;
      evt_mask_q <= evt_mask_d;
      raw_q <= gated;
      x0_sync_q <= {x0_sync_q[0], ext_input_zero_i};
      x1_sync_q <= {x1_sync_q[0], ext_input_one_i};
      ack_q <= ack_d;
      dat_q <= dat_d;
      irq_q <= irq_d;
      req_q <= req_d; // R15 R17
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign core_req_o = req_q;
  assign irq_o = irq_q;

  AST_GLOBAL_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    !pri_en_q[iepb_pkg::GIE_BIT] |=> !core_req_o.req)
    else $error("request raised with global enable off");

  AST_MASK_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    req_d.req |-> mask_vec[req_d.src] && raw[req_d.src])
    else $error("winner not enabled");

  AST_TIMER_TWO: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    flags_i.timer_two_high_overflow_flag && pri_en_q[iepb_pkg::GIE_BIT] &&
    pri_en_q[iepb_pkg::T2_BIT] && !svc_high_i && !svc_low_i |=> core_req_o.req)
    else $error("timer two high flag not passed");

  AST_TIMER_THREE: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    flags_i.timer_three_low_overflow_flag && pri_en_q[iepb_pkg::GIE_BIT] &&
    ext_en1_q[iepb_pkg::T3_BIT] && !svc_high_i && !svc_low_i |=> core_req_o.req)
    else $error("timer three low flag not passed");

  AST_FIXED_BIT_READ: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    access && !wb_we_i && idx == iepb_pkg::IDX_PRI_LVL |=> wb_ack_o && wb_dat_o[7])
    else $error("primary level bit 7 not read as one");

  AST_EN2_UNUSED: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    access && !wb_we_i && idx == iepb_pkg::IDX_EXT_EN2 |=> wb_dat_o[7:1] == 7'h00)
    else $error("unused enable bits not zero");

  AST_HIGH_SERVICE: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    svc_high_i |=> !core_req_o.req)
    else $error("request during high service");

  AST_LOW_SERVICE: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    svc_low_i |=> !core_req_o.req || core_req_o.high)
    else $error("low request during low service");

  AST_HIGH_FIRST: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    |hi_vec && !svc_high_i |=> core_req_o.req && core_req_o.high)
    else $error("high level not served first");

  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    |(evt_q & evt_mask_q) |=> irq_o)
    else $error("interrupt not raised");

  AST_RESET_CLEAR: assert property (@(posedge clk_i) // R18
    rst_i |=> pri_en_q == iepb_pkg::RST_REG && pri_lvl_q == iepb_pkg::RST_REG &&
    ext_en1_q == iepb_pkg::RST_REG && ext_lvl1_q == iepb_pkg::RST_REG &&
    !core_req_o.req && !irq_o && !wb_ack_o)
    else $error("state not cleared by reset");

  AST_SUPPLY_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    !ext_en2_q[iepb_pkg::SUPPLY_BIT] |=> !(core_req_o.req && &core_req_o.src))
    else $error("masked supply sense request passed");

  AST_LEVEL_MATCH: assert property (@(posedge clk_i) disable iff (rst_i) // R08 R16
    req_d.req |-> req_d.high == lvl_vec[req_d.src])
    else $error("request level does not match its level bit");

  // No pending source of the same level may sit below the winner
  AST_FIXED_ORDER: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    req_d.req |-> (gated & (req_d.high ? lvl_vec : ~lvl_vec) &
    ((16'h0001 << req_d.src) - 16'h0001)) == 16'h0000)
    else $error("lower order source of equal level skipped");

  AST_DETECT_ONE: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    |gated && !svc_high_i && !svc_low_i |=> core_req_o.req)
    else $error("enabled request not offered after one cycle");
endmodule
`default_nettype wire

// ### logic/iepb_pkg.sv
// Package for the interrupt enable and priority bank.
// Assumes one system clock and a Wishbone slave with word registers.
`default_nettype none
package iepb_pkg;
  localparam int NSRC = 16;
  localparam int SRC_W = 4;
  localparam int ADR_W = 12;
  localparam int REG_W = 8;
  localparam int EVT_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PRI_EN = 10'h0a8;
  localparam logic [9:0] IDX_PRI_LVL = 10'h0b8;
  localparam logic [9:0] IDX_EXT_EN1 = 10'h0e6;
  localparam logic [9:0] IDX_EXT_EN2 = 10'h0e7;
  localparam logic [9:0] IDX_EXT_LVL1 = 10'h0f6;
  localparam logic [9:0] IDX_EXT_LVL2 = 10'h0f7;
  localparam logic [9:0] IDX_EVT_STAT = 10'h010;
  localparam logic [9:0] IDX_EVT_MASK = 10'h011;
  // Field positions
  localparam int GIE_BIT = 7;
  localparam int T2_BIT = 5;
  localparam int T3_BIT = 7;
  localparam int SUPPLY_BIT = 0;
  // Reset values and fixed bits
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] PRI_LVL_FIXED = 8'h80;
  localparam logic [7:0] LOW7_MASK = 8'h7f;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  localparam logic [15:0] RST_EVT = 16'h0000;

  typedef struct packed {
    logic timer_zero_overflow_flag;
    logic timer_one_overflow_flag;
    logic uart_flag;
    logic timer_two_low_overflow_flag;
    logic timer_two_high_overflow_flag;
    logic serial_periph_flag;
    logic smbus_flag;
    logic usb_function_flag;
    logic window_compare_flag;
    logic conversion_done_flag;
    logic counter_array_flag;
    logic comparator_zero_rise_flag;
    logic comparator_zero_fall_flag;
    logic comparator_one_rise_flag;
    logic comparator_one_fall_flag;
    logic timer_three_low_overflow_flag;
    logic timer_three_high_overflow_flag;
    logic supply_sense_flag;
  } iepb_flags_s;

  typedef struct packed {
    logic req;
    logic high;
    logic [SRC_W-1:0] src;
  } iepb_core_req_s;
endpackage
`default_nettype wire
